// ---- sim/sar_adc_conversion_control_tb.sv ----
`default_nettype none
module sar_adc_conversion_control_tb;
  import sar_adc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        cs_n = 1'b1;
  logic        wr_n = 1'b1;
  logic        rd_n = 1'b1;
  logic        neg = 1'b0;
  logic [9:0]  lvl = 10'h000;
  logic [9:0]  trial;
  logic [7:0]  dat;
  logic [7:0]  oe;
  logic        done_n;
  logic        comp;
  logic [31:0] seed = 32'h1709a482;
  int          n_fail = 0;
  int          total_checks = 0;
  int          waited;
  logic        free_run = 1'b0;
  logic        kick_n = 1'b1;
  // Free-running hookup: write follows done, plus a one-off start-up kick
  wire logic   wr_pin = free_run ? (done_n & kick_n) : wr_n;
  sar_analog_model ana (.trial_code_in(trial), .level_in(lvl), .above_out(comp));
  sar_adc_conversion_control dut (.clk_in, .rst_n_in, .chip_select_n_in(cs_n),
    .write_n_in(wr_pin), .read_n_in(rd_n), .comparator_high_in(comp),
    .input_negative_dominant_in(neg), .trial_code_out(trial), .data_out(dat),
    .data_oe_out(oe), .conversion_done_n_out(done_n), .result_transfer_out());
  initial forever #2 clk_in = ~clk_in;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_flag(input logic got, input logic exp);
    check_byte({7'h00, got}, {7'h00, exp});
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Host read strobe held for a few cycles, then bus must float again
  task automatic read(input logic [7:0] exp);
    @(posedge clk_in);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (3) @(negedge clk_in);
    check_byte(oe, 8'hff);
    check_byte(dat, exp);
    @(posedge clk_in);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (3) @(negedge clk_in);
    check_byte(oe, 8'h00);
  endtask
  // Bounded wait for the done pin to reach a level; a timeout ends the run
  task automatic wait_done(input logic want);
    waited = 0;
    while (done_n !== want && waited < 200)
    begin
      @(negedge clk_in);
      waited++;
    end
    if (waited == 200)
    begin
      check_flag(1'b0, 1'b1);
      conclude();
    end
  endtask
  // Start pulse of 1 to 3 clocks, bounded wait for done, then the two-byte read-out
  task automatic convert(input logic [9:0] v, input logic ng);
    logic [9:0] exp;
    exp = ng ? 10'h000 : v;
    @(posedge clk_in);
    lvl <= v;
    neg <= ng;
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    repeat (1 + rnd() % 3) @(posedge clk_in);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    wait_done(1'b0);
    check_flag(waited inside {[80:90]}, 1'b1);
    repeat (6) @(negedge clk_in);
    read(exp[9:2]);
    check_flag(done_n, 1'b1);
    read({exp[1:0], 6'h00});
    read(exp[9:2]);
  endtask
  initial
  begin
    repeat (16) @(posedge clk_in);
    rst_n_in <= 1'b1;
    // Abort: a start in mid-search must restart the search from the top
    @(posedge clk_in);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    @(posedge clk_in);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    repeat (30) @(posedge clk_in);
    convert(10'h3ff, 1'b0);
    convert(10'h000, 1'b0);
    convert(10'h2a5, 1'b1);
    for (int i = 0; i < 8; i++) convert(10'(rnd()), 1'b0);
    // Free-running with the bus held enabled: done must still fall each round
    @(posedge clk_in);
    lvl <= 10'h1c7;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    free_run <= 1'b1;
    kick_n <= 1'b0;
    @(posedge clk_in);
    kick_n <= 1'b1;
    for (int k = 0; k < 3; k++)
    begin
      wait_done(1'b0);
      check_flag(waited inside {[80:90]}, 1'b1);
      @(negedge clk_in);
      check_byte(dat, lvl[9:2]);
      wait_done(1'b1);
    end
    @(posedge clk_in);
    free_run <= 1'b0;
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    conclude();
  end
endmodule // sar_adc_conversion_control_tb
bind sar_adc_conversion_control sar_adc_properties props (.clk_in, .rst_n_in,
  .chip_select_n_in, .write_n_in, .read_n_in, .trial_code_out, .data_oe_out,
  .conversion_done_n_out, .result_transfer_out);
`default_nettype wire

// ---- sim/sar_adc_properties.sv ----
`default_nettype none
module sar_adc_properties
  import sar_adc_pkg::*;
(
  input wire logic                clk_in,
  input wire logic                rst_n_in,
  input wire logic                chip_select_n_in,
  input wire logic                write_n_in,
  input wire logic                read_n_in,
  input wire logic [9:0]          trial_code_out,
  input wire logic [BUS_BITS-1:0] data_oe_out,
  input wire logic                conversion_done_n_out,
  input wire logic                result_transfer_out
);
  timeunit 1ns;
  timeprecision 1ps;
  wire logic  st = !chip_select_n_in && !write_n_in;
  wire logic  rq = !chip_select_n_in && !read_n_in;
  logic [7:0] age_reg;
  // Cycles since the last start; saturates so an old start never aliases
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in) age_reg <= 8'hff;
    else if (st) age_reg <= 8'h00;
    else if (age_reg != 8'hff) age_reg <= age_reg + 8'h01;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  a_bus_off: assert property (!rq |=> data_oe_out == 8'h00)
    else $error("bus driven without read");
  a_bus_on: assert property (rq |=> data_oe_out == 8'hff)
    else $error("bus idle during read");
  a_done_set: assert property (result_transfer_out |-> !conversion_done_n_out)
    else $error("transfer without done");
  a_result_transfer_once: assert property (result_transfer_out |=> !result_transfer_out)
    else $error("transfer too long");
  a_conv_time: assert property ($fell(conversion_done_n_out) |-> age_reg inside {[80:90]})
    else $error("conversion time off");
  a_held_reset: assert property (st |-> ##2 (trial_code_out == 10'h000 && conversion_done_n_out))
    else $error("search not held");
  a_msb_first: assert property (age_reg == 8'h01 && !st |-> ##[1:3] trial_code_out == 10'h200)
    else $error("first trial not msb");
  a_done_cause: assert property ($rose(conversion_done_n_out) |-> $past(rq, 2) || $past(st, 2))
    else $error("done cleared without cause");
  c_result_transfer: cover property (result_transfer_out);
  c_read: cover property (rq && !conversion_done_n_out);
  c_clear: cover property ($rose(conversion_done_n_out));
endmodule // sar_adc_properties
`default_nettype wire

// ---- sim/sar_analog_model.sv ----
`default_nettype none
module sar_analog_model
(
  input  wire logic [9:0] trial_code_in,
  input  wire logic [9:0] level_in,
  output logic            above_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Input sits half a step above level_in, so either compare sense yields level_in
  assign above_out = {level_in, 1'b1} > {trial_code_in, 1'b0};
endmodule // sar_analog_model
`default_nettype wire

// ---- src/sar_adc_conversion_control.sv ----
`default_nettype none

// Operation
// - Result read as two bytes, same bus
// - Ten decisions MSB first, then latch result
// - Conversion lasts 80 to 90 clocks
// - Unsigned straight binary, all ones full scale
// - Negative input not below positive gives zero
// - Byte one bits 9..2, byte two 1..0
// - Start held while select and write low
// - Latch transfer sets done flag, output low
// - Select and read clear flag, drive bus; code lets reads clear it only after a 4-clock hold
module sar_adc_conversion_control
  import sar_adc_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                chip_select_n_in,
  input  wire logic                write_n_in,
  input  wire logic                read_n_in,
  input  wire logic                comparator_high_in,
  input  wire logic                input_negative_dominant_in,
  output logic [RESULT_BITS-1:0]   trial_code_out,
  output logic [BUS_BITS-1:0]      data_out,
  output logic [BUS_BITS-1:0]      data_oe_out,
  output logic                     conversion_done_n_out,
  output logic                     result_transfer_out
);

  conv_state_t            state_reg;
  logic [3:0]             bit_idx_reg;
  logic [2:0]             phase_reg;
  logic [RESULT_BITS-1:0] sar_reg;
  logic [RESULT_BITS-1:0] result_reg;
  logic                   done_flag_reg;
  logic [2:0]             done_hold_reg;
  logic                   low_byte_reg;
  logic                   read_req_d_reg;
  logic                   start_req;
  logic                   read_req;
  logic                   read_end;
  logic                   decide;
  logic                   transfer;
  logic [BUS_BITS-1:0]    byte_sel;

  // Start request and bus read decode
  assign start_req = ~chip_select_n_in & ~write_n_in;
  assign read_req  = ~chip_select_n_in & ~read_n_in;
  // A strobe counts as finished whichever pin rises first, so hosts that lift
  // select and read together still advance the byte pointer
  assign read_end  = read_req_d_reg & ~read_req;
  assign decide    = (state_reg == ST_SEARCH) && (phase_reg == PHASE_LAST);
  assign transfer  = (state_reg == ST_TRANSFER);

  // Sequencer: held in reset while start is asserted, one transfer cycle at the end
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_reg   <= ST_IDLE;
      bit_idx_reg <= TOP_BIT_IDX;
      phase_reg   <= PHASE_ZERO;
    end
    else if (start_req)
    begin
      state_reg   <= ST_HELD;
      bit_idx_reg <= TOP_BIT_IDX;
      phase_reg   <= PHASE_ZERO;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          state_reg <= ST_IDLE;
        end
        ST_HELD:
        begin
          state_reg <= ST_SEARCH;
        end
        ST_SEARCH:
        begin
          // 8 clocks per bit, 80 in all, plus two control cycles
          phase_reg <= phase_reg + 3'h1;
          if (phase_reg == PHASE_LAST)
          begin
            if (bit_idx_reg == LAST_BIT_IDX)
            begin
              state_reg <= ST_TRANSFER;
            end
            else
            begin
              bit_idx_reg <= bit_idx_reg - BIT_CNT_W1;
            end
          end
        end
        ST_TRANSFER:
        begin
          state_reg <= ST_IDLE;
        end
        default:
        begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Successive approximation register, MSB tried first
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sar_reg <= RESULT_ZERO;
    end
    else if (start_req)
    begin
      sar_reg <= RESULT_ZERO;
    end
    else if (state_reg == ST_HELD)
    begin
      sar_reg[TOP_BIT_IDX] <= 1'b1;
    end
    else if (decide)
    begin
      // Keep the trial bit only if the input lies above the trial level
      sar_reg[bit_idx_reg] <= comparator_high_in & ~input_negative_dominant_in;
      if (bit_idx_reg != LAST_BIT_IDX)
      begin
        sar_reg[bit_idx_reg - BIT_CNT_W1] <= 1'b1;
      end
    end
  end

  // Output latch; a dominant negative input forces the zero code
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      result_reg <= RESULT_ZERO;
    end
    else if (transfer)
    begin
      result_reg <= input_negative_dominant_in ? RESULT_ZERO : sar_reg;
    end
  end

  // Done flag: transfer sets it and wins over a read; a hold window keeps it
  // visible even when the bus is permanently enabled
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      done_flag_reg <= 1'b0;
      done_hold_reg <= DONE_HOLD_ZERO;
    end
    else if (transfer)
    begin
      done_flag_reg <= 1'b1;
      done_hold_reg <= DONE_HOLD_INIT;
    end
    else if (start_req)
    begin
      done_flag_reg <= 1'b0;
      done_hold_reg <= DONE_HOLD_ZERO;
    end
    else if (done_hold_reg != DONE_HOLD_ZERO)
    begin
      done_hold_reg <= done_hold_reg - 3'h1;
    end
    else if (read_req)
    begin
      done_flag_reg <= 1'b0;
    end
  end

  // Byte pointer: high byte after each start or transfer, toggled by each finished read
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      low_byte_reg <= 1'b0;
      read_req_d_reg <= 1'b0;
    end
    else
    begin
      read_req_d_reg <= read_req;
      if (start_req || transfer)
      begin
        low_byte_reg <= 1'b0;
      end
      else if (read_end)
      begin
        low_byte_reg <= ~low_byte_reg;
      end
    end
  end

  // Byte layout of the result on the 8-bit bus
  assign byte_sel = low_byte_reg ? {result_reg[1:0], LOW_BYTE_PAD}
                                 : result_reg[9:2];

  // Registered pin drive; the bus floats unless select and read are low
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      data_out              <= BYTE_ZERO;
      data_oe_out           <= BYTE_ZERO;
      conversion_done_n_out <= 1'b1;
      result_transfer_out   <= 1'b0;
      trial_code_out        <= RESULT_ZERO;
    end
    else
    begin
      data_out              <= byte_sel;
      data_oe_out           <= {BUS_BITS{read_req}};
      conversion_done_n_out <= ~(done_flag_reg | transfer);
      result_transfer_out   <= transfer;
      trial_code_out        <= sar_reg;
    end
  end

endmodule // sar_adc_conversion_control

`default_nettype wire

// ---- src/sar_adc_pkg.sv ----
`default_nettype none

package sar_adc_pkg;

  localparam int unsigned RESULT_BITS      = 10;
  localparam int unsigned BUS_BITS         = 8;
  localparam int unsigned CYCLES_PER_BIT   = 8;
  // Search takes 10 decisions of 8 conversion clocks each, 80 in all
  localparam int unsigned SEARCH_CYCLES    = RESULT_BITS * CYCLES_PER_BIT;
  // Done flag stays set at least this long against reads; a new start still clears it at once
  localparam int unsigned DONE_HOLD_CYCLES = 4;
  localparam logic [3:0]  BIT_CNT_W1       = 4'h1;
  localparam logic [3:0]  LAST_BIT_IDX     = 4'h0;
  localparam logic [3:0]  TOP_BIT_IDX      = 4'h9;
  localparam logic [2:0]  PHASE_LAST       = 3'h7;
  localparam logic [2:0]  PHASE_ZERO       = 3'h0;
  localparam logic [2:0]  DONE_HOLD_INIT   = 3'h4;
  localparam logic [2:0]  DONE_HOLD_ZERO   = 3'h0;
  localparam logic [9:0]  RESULT_ZERO      = 10'h000;
  localparam logic [7:0]  BYTE_ZERO        = 8'h00;
  localparam logic [5:0]  LOW_BYTE_PAD     = 6'h00;
  // Conversion clock limits in kHz, kept as documentation for the bench
  localparam int unsigned CONV_CLK_MIN_KHZ = 200;
  localparam int unsigned CONV_CLK_MAX_KHZ = 2600;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HELD,
    ST_SEARCH,
    ST_TRANSFER
  } conv_state_t;

endpackage : sar_adc_pkg

`default_nettype wire
